// [verilog/ocfg_pkg.sv]
/*
  Constants for the one-time-programmable configuration bank: register
  offsets, field positions, reset values and built-in defaults.
  Assumes an 8-bit register port addressed by byte offset.
*/
package ocfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_OVERRIDE = 8'h07;
  localparam logic [7:0] OFS_TOGGLE_PIN_SELECT = 8'h0a;
  localparam logic [7:0] OFS_PIN_DIRECTION_LOW = 8'h0b;
  localparam logic [7:0] OFS_PIN_DIRECTION_HIGH = 8'h0c;
  localparam logic [7:0] OFS_PIN_IRQ_MASK_LOW = 8'h0d;
  localparam logic [7:0] OFS_PIN_IRQ_MASK_HIGH = 8'h0e;
  localparam logic [7:0] OFS_LATENCY_THRESHOLD_BYTE0 = 8'h0f;
  localparam logic [7:0] OFS_LATENCY_THRESHOLD_BYTE1 = 8'h10;
  localparam logic [7:0] OFS_LATENCY_THRESHOLD_BYTE2 = 8'h11;
  localparam logic [7:0] OFS_MAKER_IDENT_LOW = 8'h12;
  localparam logic [7:0] OFS_MAKER_IDENT_HIGH = 8'h13;
  localparam logic [7:0] OFS_PART_IDENT_LOW = 8'h14;
  localparam logic [7:0] OFS_PART_IDENT_HIGH = 8'h15;
  localparam logic [7:0] OFS_BUS_POWER_BUDGET = 8'h16;
  localparam logic [7:0] OFS_DESCRIPTOR_ATTRIBUTES = 8'h17;
  localparam logic [7:0] OFS_RELEASE_NUMBER_MAJOR = 8'h18;
  localparam logic [7:0] OFS_RELEASE_NUMBER_MINOR = 8'h19;
  localparam logic [7:0] OFS_PROG_FLAGS = 8'h1e;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_RX_TOGGLE = 1;
  localparam int BIT_TX_TOGGLE = 0;
  localparam int BIT_WAKE_EN = 3;
  localparam int BIT_WAKE_VALID = 2;
  localparam int BIT_OVR_MASK = 3;
  localparam int BIT_OVR_DIR = 2;
  localparam int BIT_OVR_MODE = 1;
  localparam int BIT_PRG_VID = 0;
  localparam int BIT_PRG_PID = 1;
  localparam int BIT_PRG_POWER = 2;
  localparam int BIT_PRG_ATTR = 3;
  localparam int BIT_PRG_RELEASE = 4;
  localparam int BIT_ATTR_D5 = 5;
  localparam int BIT_ATTR_SELF = 6;
  localparam int BIT_ATTR_D7 = 7;

  // ----------------------------------------------------------------------
  // Reset values, power-mode codes and descriptor limits.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] PWR_BUS = 2'h0;
  localparam logic [1:0] PWR_INVALID = 2'h3;
  localparam logic [7:0] MAX_POWER_LOW = 8'h01;
  localparam logic [7:0] MAX_POWER_HIGH = 8'hfa;
  localparam logic [4:0] LAST_INDEX = 5'h1f;

  // Built-in defaults used when a field is not flagged or not overridden.
  // Identifier defaults are arbitrary neutral values.
  localparam logic [15:0] DEF_MAKER_IDENT = 16'h1234;
  localparam logic [15:0] DEF_PART_IDENT = 16'h5678;
  localparam logic [7:0] DEF_MAX_POWER = 8'h32;
  localparam logic [15:0] DEF_RELEASE = 16'h0100;
  localparam logic [9:0] DEF_PIN_DIRECTION = 10'h000;
  localparam logic [9:0] DEF_PIN_IRQ_MASK = 10'h000;

  // Loader states.
  typedef enum logic [1:0] {OCFG_LOAD, OCFG_READY} ocfg_state_t;

endpackage

// [verilog/ocfg_store.sv]
/*
  Flip-flop store standing for the one-time-programmable array.
  A location written once keeps its value; later writes are ignored until a reset clears its written mark.
  Assumes a single clock and a synchronous active-high reset that clears
  the volatile written marks and the read output, never the cells.
*/
`timescale 1ns/1ps
module ocfg_store
  import ocfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic [4:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  input wire logic [4:0] i_rd_idx,
  output logic [7:0] o_rd_data
);

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  // Cell contents; a blank part reads zero, and reset never touches them.
  logic [7:0] mem [32] = '{default: RESET_BYTE};
  logic [31:0] burnt; // One mark per cell; a burnt cell is frozen.
  logic [31:0] next_burnt;
  logic [7:0] next_cell;

  // Compute the new burn marks and the value to write.
  always_comb
  begin
    next_burnt = burnt;
    next_cell = mem[i_wr_idx];
    if (i_wr && !burnt[i_wr_idx])
    begin
      next_burnt[i_wr_idx] = 1'b1;
      next_cell = i_wr_data;
    end
  end

  // Register the cells. Reset forgets only the burn marks, so bytes burnt
  // before a reset are still there for the loader to sweep afterwards.
  // Limitation: a cell may be burnt again after a reset in this model.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      burnt <= '0;
    end
    else
    begin
      burnt <= next_burnt;
      mem[i_wr_idx] <= next_cell;
    end
  end

  // Read is registered so the output comes from a flip-flop.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rd_data <= RESET_BYTE;
    end
    else
    begin
      o_rd_data <= mem[i_rd_idx];
    end
  end

endmodule // ocfg_store

// [verilog/ocfg_bank.sv]
/*
  Configuration bank top: programs the OTP store from the USB side,
  shadows it into working registers after reset and drives the pin and
  descriptor settings. Assumes the USB core owns the byte port and waits
  for o_cfg_ready before enumerating.
*/
`timescale 1ns/1ps
module ocfg_bank
  import ocfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [9:0] i_pin_in,
  input wire logic i_tx_toggle,
  input wire logic i_rx_toggle,
  input wire logic [9:0] i_gpio_out,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_cfg_ready,
  output logic [9:0] o_pin_out,
  output logic [9:0] o_pin_oe,
  output logic o_pin_event,
  output logic [23:0] o_latency_baud_threshold,
  output logic [15:0] o_maker_ident,
  output logic [15:0] o_part_ident,
  output logic [7:0] o_max_power,
  output logic [7:0] o_bm_attributes,
  output logic o_power_invalid,
  output logic [15:0] o_release
);

  // ----------------------------------------------------------------------
  // Store and loader.
  // ----------------------------------------------------------------------
  logic [7:0] shadow [32]; // Working copy of the store, read by logic.
  logic [7:0] next_shadow_byte;
  logic [4:0] load_idx; // Address currently fetched from the store.
  logic [4:0] next_load_idx;
  logic load_take; // A fetched byte is on the store output.
  logic next_load_take;
  logic [4:0] take_idx; // Index of that fetched byte.
  logic [4:0] next_take_idx;
  ocfg_state_t state;
  ocfg_state_t next_state;
  logic [7:0] store_rd;
  logic [4:0] store_rd_idx;
  logic prog_wr; // Host program strobe for an in-range offset.

  assign prog_wr = i_wr && (i_addr[7:5] == 3'h0);
  // While loading the store is swept; afterwards host reads go through it.
  assign store_rd_idx = (state == OCFG_LOAD) ? load_idx : i_addr[4:0];

  ocfg_store u_store (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr(prog_wr),
    .i_wr_idx(i_addr[4:0]),
    .i_wr_data(i_wdata),
    .i_rd_idx(store_rd_idx),
    .o_rd_data(store_rd)
  );

  // Sweep every cell into the shadow once after reset.
  always_comb
  begin
    next_state = state;
    next_load_idx = load_idx;
    next_load_take = 1'b0;
    next_take_idx = load_idx;
    next_shadow_byte = store_rd;
    unique case (state)
      OCFG_LOAD:
      begin
        next_load_take = 1'b1;
        if (load_idx != LAST_INDEX)
        begin
          next_load_idx = load_idx + 5'h1;
        end
        if (load_take && take_idx == LAST_INDEX)
        begin
          next_state = OCFG_READY;
        end
      end
      OCFG_READY:
      begin
        next_load_take = 1'b0;
      end
    endcase
  end

  // Register loader state. Programming after load does not disturb the
  // shadow: a fresh burn only takes effect after the next reset, as in OTP.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= OCFG_LOAD;
      load_idx <= 5'h0;
      load_take <= 1'b0;
      take_idx <= 5'h0;
      for (int k = 0; k < 32; k++)
      begin
        shadow[k] <= RESET_BYTE;
      end
    end
    else
    begin
      state <= next_state;
      load_idx <= next_load_idx;
      load_take <= next_load_take;
      take_idx <= next_take_idx;
      if (load_take)
      begin
        shadow[take_idx] <= next_shadow_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Host read answer.
  // ----------------------------------------------------------------------
  logic rd_pend; // Read taken, data arrives from the store next cycle.
  logic next_rd_pend;
  logic next_rvalid;
  logic [7:0] next_rdata;

  // Reads are honoured only once loading is done; unmapped offsets read 0.
  always_comb
  begin
    next_rd_pend = i_rd && (state == OCFG_READY) && (i_addr[7:5] == 3'h0);
    next_rvalid = rd_pend;
    next_rdata = rd_pend ? store_rd : RESET_BYTE;
    if (i_rd && (state == OCFG_READY) && (i_addr[7:5] != 3'h0))
    begin
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rd_pend <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= RESET_BYTE;
    end
    else
    begin
      rd_pend <= next_rd_pend;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Effective settings from shadow, flags and overrides.
  // ----------------------------------------------------------------------
  logic [7:0] ovr;
  logic [7:0] prg;
  logic [7:0] attr;
  logic [9:0] eff_dir;
  logic [9:0] eff_mask;
  logic [1:0] eff_toggle;
  logic [7:0] eff_attr;

  assign ovr = shadow[OFS_OVERRIDE[4:0]];
  assign prg = shadow[OFS_PROG_FLAGS[4:0]];
  assign attr = prg[BIT_PRG_ATTR] ? shadow[OFS_DESCRIPTOR_ATTRIBUTES[4:0]] : RESET_BYTE;

  // Pin and descriptor settings; defaults apply unless enabled or flagged.
  always_comb
  begin
    eff_dir = ovr[BIT_OVR_DIR] ? {shadow[OFS_PIN_DIRECTION_HIGH[4:0]][1:0],
                                  shadow[OFS_PIN_DIRECTION_LOW[4:0]]}
                               : DEF_PIN_DIRECTION;
    eff_mask = ovr[BIT_OVR_MASK] ? {shadow[OFS_PIN_IRQ_MASK_HIGH[4:0]][1:0],
                                    shadow[OFS_PIN_IRQ_MASK_LOW[4:0]]}
                                 : DEF_PIN_IRQ_MASK;
    eff_toggle = ovr[BIT_OVR_MODE] ? shadow[OFS_TOGGLE_PIN_SELECT[4:0]][1:0] : 2'h0;
    eff_attr = 8'h00;
    eff_attr[BIT_ATTR_D7] = 1'b1;
    eff_attr[BIT_ATTR_SELF] = (attr[1:0] != PWR_BUS) && (attr[1:0] != PWR_INVALID);
    eff_attr[BIT_ATTR_D5] = attr[BIT_WAKE_VALID] && attr[BIT_WAKE_EN];
  end

  // ----------------------------------------------------------------------
  // Pins and change-of-state events.
  // ----------------------------------------------------------------------
  logic [9:0] pin_meta; // First synchroniser stage, read only by pin_sync.
  logic [9:0] pin_sync;
  logic [9:0] pin_prev;
  logic [9:0] next_pin_out;
  logic [9:0] next_pin_oe;
  logic next_event;

  // Pin drive: toggle functions take over pins 8 and 9 as outputs.
  always_comb
  begin
    next_pin_out = i_gpio_out;
    next_pin_oe = eff_dir;
    if (eff_toggle[BIT_TX_TOGGLE])
    begin
      next_pin_out[8] = i_tx_toggle;
      next_pin_oe[8] = 1'b1;
    end
    if (eff_toggle[BIT_RX_TOGGLE])
    begin
      next_pin_out[9] = i_rx_toggle;
      next_pin_oe[9] = 1'b1;
    end
    // Only unmasked inputs report a change; nothing before load completes.
    next_event = (state == OCFG_READY)
               && (|((pin_sync ^ pin_prev) & ~next_pin_oe & ~eff_mask));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
      pin_prev <= 10'h000;
      o_pin_out <= 10'h000;
      o_pin_oe <= 10'h000;
      o_pin_event <= 1'b0;
    end
    else
    begin
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe;
      o_pin_event <= next_event;
    end
  end

  // ----------------------------------------------------------------------
  // Descriptor outputs, registered.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_cfg_ready <= 1'b0;
      o_latency_baud_threshold <= 24'h000000;
      o_maker_ident <= DEF_MAKER_IDENT;
      o_part_ident <= DEF_PART_IDENT;
      o_max_power <= DEF_MAX_POWER;
      o_bm_attributes <= 8'h80;
      o_power_invalid <= 1'b0;
      o_release <= DEF_RELEASE;
    end
    else
    begin
      o_cfg_ready <= (state == OCFG_READY);
      o_latency_baud_threshold <= {shadow[OFS_LATENCY_THRESHOLD_BYTE2[4:0]],
                                   shadow[OFS_LATENCY_THRESHOLD_BYTE1[4:0]],
                                   shadow[OFS_LATENCY_THRESHOLD_BYTE0[4:0]]};
      o_maker_ident <= prg[BIT_PRG_VID] ? {shadow[OFS_MAKER_IDENT_HIGH[4:0]],
                                           shadow[OFS_MAKER_IDENT_LOW[4:0]]}
                                        : DEF_MAKER_IDENT;
      o_part_ident <= prg[BIT_PRG_PID] ? {shadow[OFS_PART_IDENT_HIGH[4:0]],
                                          shadow[OFS_PART_IDENT_LOW[4:0]]}
                                       : DEF_PART_IDENT;
      o_max_power <= prg[BIT_PRG_POWER] ? shadow[OFS_BUS_POWER_BUDGET[4:0]]
                                        : DEF_MAX_POWER;
      o_bm_attributes <= eff_attr;
      o_power_invalid <= (attr[1:0] == PWR_INVALID);
      o_release <= prg[BIT_PRG_RELEASE] ? {shadow[OFS_RELEASE_NUMBER_MAJOR[4:0]],
                                           shadow[OFS_RELEASE_NUMBER_MINOR[4:0]]}
                                        : DEF_RELEASE;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  a_ready_after_load: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cfg_ready |-> state == OCFG_READY)
    else $error("Ready raised before load finished.");
  a_load_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(i_srst) |-> ##[30:40] o_cfg_ready)
    else $error("Load did not finish in time.");
  a_rx_toggle: assert property (@(posedge i_clk) disable iff (i_srst)
    eff_toggle[BIT_RX_TOGGLE] |=> o_pin_oe[9] && o_pin_out[9] == $past(i_rx_toggle))
    else $error("Rx toggle not on pin 9.");
  a_tx_toggle: assert property (@(posedge i_clk) disable iff (i_srst)
    eff_toggle[BIT_TX_TOGGLE] |=> o_pin_oe[8] && o_pin_out[8] == $past(i_tx_toggle))
    else $error("Tx toggle not on pin 8.");
  a_dir_low: assert property (@(posedge i_clk) disable iff (i_srst)
    ovr[BIT_OVR_DIR] |=> o_pin_oe[7:0] == $past(shadow[OFS_PIN_DIRECTION_LOW[4:0]]))
    else $error("Low direction not applied.");
  a_dir_high: assert property (@(posedge i_clk) disable iff (i_srst)
    ovr[BIT_OVR_DIR] && !eff_toggle[0] |=> o_pin_oe[8] == $past(shadow[OFS_PIN_DIRECTION_HIGH[4:0]][0]))
    else $error("Pin 8 direction not applied.");
  a_mask_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (&eff_mask) |=> !o_pin_event)
    else $error("Masked pins raised an event.");
  a_mask_high: assert property (@(posedge i_clk) disable iff (i_srst)
    eff_mask[9:8] == 2'h3 && eff_mask[7:0] == 8'hff |-> ##1 !o_pin_event)
    else $error("High mask did not gate events.");
  a_threshold: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 o_latency_baud_threshold[23:16] == $past(shadow[OFS_LATENCY_THRESHOLD_BYTE2[4:0]]))
    else $error("Threshold high byte wrong.");
  a_vid_default: assert property (@(posedge i_clk) disable iff (i_srst)
    !prg[BIT_PRG_VID] |=> o_maker_ident == DEF_MAKER_IDENT)
    else $error("Unflagged vendor field used.");
  a_vid_order: assert property (@(posedge i_clk) disable iff (i_srst)
    prg[BIT_PRG_VID] |=> o_maker_ident[15:8] == $past(shadow[OFS_MAKER_IDENT_HIGH[4:0]]))
    else $error("Vendor high byte wrong.");
  a_pid_order: assert property (@(posedge i_clk) disable iff (i_srst)
    prg[BIT_PRG_PID] |=> o_part_ident[7:0] == $past(shadow[OFS_PART_IDENT_LOW[4:0]]))
    else $error("Product low byte wrong.");
  a_wake_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    !attr[BIT_WAKE_VALID] |=> !o_bm_attributes[BIT_ATTR_D5])
    else $error("Wakeup advertised without valid.");
  a_wake_copy: assert property (@(posedge i_clk) disable iff (i_srst)
    attr[BIT_WAKE_VALID] |=> o_bm_attributes[BIT_ATTR_D5] == $past(attr[BIT_WAKE_EN]))
    else $error("Wakeup enable not copied.");
  a_power_mode: assert property (@(posedge i_clk) disable iff (i_srst)
    attr[1:0] == PWR_BUS |=> !o_bm_attributes[BIT_ATTR_SELF] && !o_power_invalid)
    else $error("Bus powered mode misreported.");
  a_release: assert property (@(posedge i_clk) disable iff (i_srst)
    prg[BIT_PRG_RELEASE] |=> o_release[15:8] == $past(shadow[OFS_RELEASE_NUMBER_MAJOR[4:0]]))
    else $error("Major release wrong.");
  a_max_power: assert property (@(posedge i_clk) disable iff (i_srst)
    prg[BIT_PRG_POWER] |=> o_max_power == $past(shadow[OFS_BUS_POWER_BUDGET[4:0]]))
    else $error("Max power byte wrong.");

endmodule // ocfg_bank

// [dv/ocfg_host_model.sv]
/*
  USB host model: burns configuration bytes and reads them back over
  the byte port of the bank. Assumes the bank samples on rising edges.
*/
`timescale 1ns/1ps
module ocfg_host_model
  import ocfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // ----------------------------------------------------------------
  // Idle levels.
  // ----------------------------------------------------------------
  // The strobes idle low from time zero.
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'hff;
  end

  // ----------------------------------------------------------------
  // Bus tasks.
  // ----------------------------------------------------------------
  // One write pulse; reserved bits go out as zero and the power byte is
  // kept in range, as a careful programmer would. Released lines show
  // the inverse of the last value so stale data never looks valid.
  task automatic burn(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] keep;
    logic [7:0] v;
    keep = 8'hff;
    if (a == OFS_OVERRIDE)
      keep = 8'h1f;
    if (a == OFS_TOGGLE_PIN_SELECT || a == OFS_PIN_DIRECTION_HIGH || a == OFS_PIN_IRQ_MASK_HIGH)
      keep = 8'h03;
    if (a == OFS_DESCRIPTOR_ATTRIBUTES)
      keep = 8'h0f;
    // The byte is settled first so each line changes once per step.
    v = d & keep;
    if (a == OFS_BUS_POWER_BUDGET && v > MAX_POWER_HIGH)
      v = MAX_POWER_HIGH;
    if (a == OFS_BUS_POWER_BUDGET && v < MAX_POWER_LOW)
      v = MAX_POWER_LOW;
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = v;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~o_wdata;
  endtask

  // One read pulse; the address is held for all four answer cycles, answer or not.
  task automatic fetch(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    repeat (4)
    begin
      if (i_rvalid === 1'b1 && ok === 1'b0)
      begin
        ok = 1'b1;
        d = i_rdata;
      end
      @(posedge i_clk);
      #1;
    end
    o_addr = ~a;
  endtask
endmodule // ocfg_host_model

// [dv/ocfg_bank_tb.sv]
/*
  Self-checking bench for the configuration bank: defaults, programming,
  loading, pin routing and event masking. Assumes the store keeps its
  data across reset and only forgets which cells were written.
*/
`timescale 1ns/1ps
module ocfg_bank_tb;
  import ocfg_pkg::*;

  // Stimulus and observed signals.
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [9:0] i_pin_in = 10'h000;
  logic i_tx_toggle = 1'b0;
  logic i_rx_toggle = 1'b0;
  logic [9:0] i_gpio_out = 10'h3a5;
  logic wr, rd, rvalid, ready, pin_event, power_invalid;
  logic [7:0] addr, wdata, rdata, max_power, bm_attr;
  logic [9:0] pin_out, pin_oe;
  logic [23:0] threshold;
  logic [15:0] maker, part, release_no;
  logic [7:0] d;
  logic ok;
  int bad_count = 0;
  int checks = 0;
  // Address and data pairs burnt in the main programming pass.
  logic [15:0] prog_tab[19] = '{16'h070e, 16'h0a02, 16'h0b0f, 16'h0c02, 16'h0d30,
    16'h0e00, 16'h0f11, 16'h1022, 16'h1133, 16'h12cd, 16'h13ab, 16'h1434,
    16'h1512, 16'h16fa, 16'h170d, 16'h1802, 16'h1907, 16'h1e1f, 16'h1299};

  // ----------------------------------------------------------------
  // Clock, design and host.
  // ----------------------------------------------------------------
  // 10 MHz clock.
  always #50 i_clk = ~i_clk;

  ocfg_bank i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_pin_in(i_pin_in), .i_tx_toggle(i_tx_toggle),
    .i_rx_toggle(i_rx_toggle), .i_gpio_out(i_gpio_out), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_cfg_ready(ready), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pin_event(pin_event), .o_latency_baud_threshold(threshold),
    .o_maker_ident(maker), .o_part_ident(part), .o_max_power(max_power),
    .o_bm_attributes(bm_attr), .o_power_invalid(power_invalid), .o_release(release_no));

  ocfg_host_model i_host (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares any value up to 32 bits, so paired identifiers fit whole.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Lets n edges pass and settles just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Reset for 20 cycles, then wait a bounded time for the load to end.
  task automatic restart();
    int n;
    n = 0;
    tick(1);
    i_srst = 1'b1;
    tick(20);
    i_srst = 1'b0;
    while (ready !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    chk(ready, 1'b1);
  endtask

  // Flips one input pin and reports whether an event pulse followed.
  task automatic t_event(input int p, input logic exp);
    logic seen;
    seen = 1'b0;
    i_pin_in[p] = ~i_pin_in[p];
    repeat (8)
    begin
      tick(1);
      if (pin_event === 1'b1)
        seen = 1'b1;
    end
    chk(seen, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  // Blank part: early reads are dropped and built-in defaults show.
  task automatic t_defaults();
    tick(20);
    i_srst = 1'b0;
    i_host.fetch(OFS_MAKER_IDENT_LOW, d, ok);
    chk(ok, 1'b0);
    i_srst = 1'b1;
    restart();
    chk({maker, part}, {DEF_MAKER_IDENT, DEF_PART_IDENT});
    chk({max_power, release_no}, {DEF_MAX_POWER, DEF_RELEASE});
    chk({bm_attr, pin_oe}, 18'h20000);
    chk(threshold, 24'h000000);
  endtask

  // Full programming pass, one-shot cells, then the loaded results.
  task automatic t_program();
    foreach (prog_tab[k])
      i_host.burn(prog_tab[k][15:8], prog_tab[k][7:0]);
    i_host.fetch(OFS_MAKER_IDENT_LOW, d, ok);
    chk({ok, d}, 9'h1cd);
    i_host.fetch(8'h40, d, ok);
    chk({ok, d}, 9'h100);
    restart();
    chk(threshold, 24'h332211);
    chk({maker, part}, 32'habcd1234);
    chk({max_power, release_no}, 24'hfa0207);
    chk({bm_attr, power_invalid}, 9'h1c0);
    tick(2);
    chk(pin_oe, 10'h20f);
    chk(pin_out[3:0], 4'h5);
    i_rx_toggle = 1'b1;
    tick(2);
    chk(pin_out[9], 1'b1);
    i_rx_toggle = 1'b0;
    tick(2);
    chk(pin_out[9], 1'b0);
    t_event(7, 1'b1);
    t_event(4, 1'b0);
    t_event(8, 1'b1);
  endtask

  // Overrides off for direction, wakeup not advertised, power mode 11.
  task automatic t_gating();
    i_host.burn(OFS_OVERRIDE, 8'h02);
    i_host.burn(OFS_TOGGLE_PIN_SELECT, 8'h01);
    i_host.burn(OFS_PIN_DIRECTION_LOW, 8'hff);
    i_host.burn(OFS_DESCRIPTOR_ATTRIBUTES, 8'h0b);
    i_host.burn(OFS_PROG_FLAGS, 8'h08);
    restart();
    tick(2);
    chk(pin_oe[7:0], 8'h00);
    chk({maker, max_power}, {DEF_MAKER_IDENT, DEF_MAX_POWER});
    chk({bm_attr[5], power_invalid}, 2'b01);
    i_tx_toggle = 1'b1;
    tick(2);
    chk(pin_out[8], 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence.
  // ----------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The whole run needs well under 2000 cycles; stop a hang at 10000.
  initial
  begin
    #1000000;
    bad_count++;
    summarize();
  end

  initial
  begin
    t_defaults();
    t_program();
    restart();
    t_gating();
    summarize();
  end
endmodule // ocfg_bank_tb
